// >>> src/cpu_ctl_pkg.sv
// Shared constants, types and register map of the cycle and status flag block
package cpu_ctl_pkg;

  // ***********************************************************
  // Interrupt levels
  // ***********************************************************
  localparam int unsigned LEVELS = 27;
  localparam int unsigned LVL_CHECK = 24;
  localparam int unsigned LVL_TRACE = 25;
  localparam int unsigned LVL_ENGINEER = 26;

  // ***********************************************************
  // Register offsets (byte addresses)
  // ***********************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FIELDS = 8'h08;
  localparam logic [7:0] OFS_LEVELS = 8'h0C;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_TIMER = 8'h14;

  // ***********************************************************
  // Field positions
  // ***********************************************************
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_STEP = 1;
  localparam int unsigned TIMER_MOD0 = 0;
  localparam int unsigned ST_FIC = 0;
  localparam int unsigned ST_SIC = 1;
  localparam int unsigned ST_IA = 2;
  localparam int unsigned ST_EXEC = 3;
  localparam int unsigned ST_FEXEC = 4;
  localparam int unsigned ST_SEXEC = 5;
  localparam int unsigned ST_TEXEC = 6;
  localparam int unsigned ST_FLAG_A = 7;
  localparam int unsigned ST_VIOL = 8;
  localparam int unsigned ST_PARITY = 9;
  localparam int unsigned ST_CARRY = 10;
  localparam int unsigned ST_OVF = 11;
  localparam int unsigned ST_TIMER_STOP = 12;
  localparam int unsigned ST_STOPPED = 13;
  localparam int unsigned ST_PHASE_LSB = 16;
  localparam int unsigned FLD_OP_LSB = 0;
  localparam int unsigned FLD_FORMAT = 5;
  localparam int unsigned FLD_TAG_LSB = 6;
  localparam int unsigned FLD_MOD8 = 8;
  localparam int unsigned FLD_MOD9 = 9;

  // ***********************************************************
  // Reset values and codes
  // ***********************************************************
  localparam logic RUN_RST = 1'b1;
  localparam logic TIMER_STOP_RST = 1'b1;
  localparam logic [LEVELS-1:0] MASK_RST = 27'h0000000;
  localparam logic [4:0] OP_CONDITIONAL_BRANCH_SKIP = 5'h09;
  localparam logic [31:0] VALID_OPS_DEFAULT = 32'hFFFF_FFFE;

  // ***********************************************************
  // Types
  // ***********************************************************
  typedef enum logic [7:0] {
    PH_ZERO = 8'h01, PH_ONE = 8'h02, PH_TWO = 8'h04, PH_THREE = 8'h08,
    PH_FOUR = 8'h10, PH_FIVE = 8'h20, PH_SIX = 8'h40, PH_SEVEN = 8'h80
  } phase_t;

  typedef struct packed {
    logic wr_gate;
    logic protect_bit;
    logic parity_sample;
    logic write_use;
    logic parity_bit;
    logic io_data_cycle;
    logic buf_reset;
  } mem_ev_t;

  typedef struct packed {
    logic arith_carry;
    logic arith_ovf;
    logic shift_left;
    logic acc_bit0;
    logic load_status;
    logic ls_bit14;
    logic ls_clr_carry;
    logic ls_set_ovf;
    logic ls_clr_ovf;
    logic shift_left_count;
    logic branch_both;
    logic shift_cnt_zero;
    logic bsc_test_carry;
    logic bsc_test_ovf;
  } dp_ev_t;

endpackage

// >>> src/cpu_cycle_and_status_flags.sv
// Instruction cycle sequencing, op fields, check flags and interrupt levels
`timescale 1ns/1ps

// Notes on behaviour
// RULE1: invalid op at phase four sets flag_a
// RULE2: write to protected word sets violation flag
// RULE3: violation outside io data raises check level
// RULE4: parity mismatch while sampling sets parity flag
// RULE5: parity error outside io data raises check
// RULE6: first cycle set at end-op phase zero
// RULE7: second cycle follows two-word first cycle
// RULE8: indirect cycle for two-word indirect instruction
// RULE9: execute set after instruction cycles until end
// RULE10: first execute lasts one cycle, then later
// RULE11: timer command bit0 starts or stops timer
// RULE12: levels 0..26 set by unmasked requests
// RULE13: branch out of interrupt clears level
// RULE14: op bits load at phase two
// RULE15: format flag loads at phase two
// RULE16: tag bits load at phase two
// RULE17: modifier 8 from buffer or interlock
// RULE18: modifier 9 marks branch out of interrupt
// RULE19: carry set conditions
// RULE20: carry clear conditions
// RULE21: overflow set and clear conditions
// RULE22: address bus gated in address cycle or stop
// RULE23: op register reset at first cycle zero
// RULE24: eight phases sequence every machine cycle
module cpu_cycle_and_status_flags #(
  parameter logic [31:0] VALID_OPS = cpu_ctl_pkg::VALID_OPS_DEFAULT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] buffer_word_i,
  input wire cpu_ctl_pkg::mem_ev_t mem_ev_i,
  input wire cpu_ctl_pkg::dp_ev_t dp_ev_i,
  input wire logic end_op_i,
  input wire logic add_to_storage_interlock_i,
  input wire logic storage_address_cycle_i,
  input wire logic [4:0] service_level_i,
  input wire logic [cpu_ctl_pkg::LEVELS-1:0] level_request_i,
  output logic [7:0] phase_o,
  output logic first_instruction_cycle_o,
  output logic second_instruction_cycle_o,
  output logic indirect_cycle_o,
  output logic execute_cycle_o,
  output logic first_execute_cycle_o,
  output logic flag_a_o,
  output logic storage_violation_flag_o,
  output logic parity_error_flag_o,
  output logic carry_flag_o,
  output logic overflow_flag_o,
  output logic timer_a_stop_o,
  output logic [cpu_ctl_pkg::LEVELS-1:0] level_o,
  output logic address_bus_gate_o,
  output logic op_register_reset_o
);

  // Bit n in the machine's numbering, bit 0 being the most significant
  function automatic logic word_bit(input logic [15:0] w, input int unsigned n);
    word_bit = w[4'(15 - n)];
  endfunction

  function automatic logic [31:0] mask_bytes(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    mask_bytes = r;
  endfunction

  // ***********************************************************
  // Register bus
  // ***********************************************************
  logic run_r;
  logic step_r;
  logic wb_ack_r;
  logic [31:0] wb_dat_r;
  logic [cpu_ctl_pkg::LEVELS-1:0] mask_r;
  logic bus_req;
  logic bus_wr;
  logic [31:0] ctrl_wv;
  logic [31:0] timer_wv;
  logic [31:0] mask_wv;

  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_r;
  assign bus_wr = bus_req & wb_we_i;
  assign ctrl_wv = mask_bytes({31'h0, run_r}, wb_dat_i, wb_sel_i);
  assign timer_wv = mask_bytes(32'h0, wb_dat_i, wb_sel_i);
  assign mask_wv = mask_bytes({5'h00, mask_r}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_r <= 1'b0;
    end else begin
      wb_ack_r <= bus_req;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r <= cpu_ctl_pkg::RUN_RST;
      step_r <= 1'b0;
    end else begin
      step_r <= 1'b0;
      if (bus_wr && wb_adr_i == cpu_ctl_pkg::OFS_CTRL) begin
        run_r <= ctrl_wv[cpu_ctl_pkg::CTRL_RUN];
        step_r <= ctrl_wv[cpu_ctl_pkg::CTRL_STEP] & wb_sel_i[0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_r <= cpu_ctl_pkg::MASK_RST;
    end else if (bus_wr && wb_adr_i == cpu_ctl_pkg::OFS_MASK) begin
      mask_r <= mask_wv[cpu_ctl_pkg::LEVELS-1:0];
    end
  end

  // ***********************************************************
  // Phase clock
  // ***********************************************************
  cpu_ctl_pkg::phase_t phase_r;
  cpu_ctl_pkg::phase_t phase_nxt;
  logic adv;
  logic at_zero;
  logic at_two;
  logic at_four;

  // A stopped clock advances one phase per step write
  assign adv = run_r | step_r;
  assign at_zero = adv & (phase_r == cpu_ctl_pkg::PH_ZERO);
  assign at_two = adv & (phase_r == cpu_ctl_pkg::PH_TWO);
  assign at_four = adv & (phase_r == cpu_ctl_pkg::PH_FOUR);

  always_comb begin
    case (phase_r)
      cpu_ctl_pkg::PH_ZERO: phase_nxt = cpu_ctl_pkg::PH_ONE;
      cpu_ctl_pkg::PH_ONE: phase_nxt = cpu_ctl_pkg::PH_TWO;
      cpu_ctl_pkg::PH_TWO: phase_nxt = cpu_ctl_pkg::PH_THREE;
      cpu_ctl_pkg::PH_THREE: phase_nxt = cpu_ctl_pkg::PH_FOUR;
      cpu_ctl_pkg::PH_FOUR: phase_nxt = cpu_ctl_pkg::PH_FIVE;
      cpu_ctl_pkg::PH_FIVE: phase_nxt = cpu_ctl_pkg::PH_SIX;
      cpu_ctl_pkg::PH_SIX: phase_nxt = cpu_ctl_pkg::PH_SEVEN;
      cpu_ctl_pkg::PH_SEVEN: phase_nxt = cpu_ctl_pkg::PH_ZERO;
      default: phase_nxt = cpu_ctl_pkg::PH_ZERO;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_r <= cpu_ctl_pkg::PH_ZERO;
    end else if (adv) begin
      phase_r <= phase_nxt; // RULE24
    end
  end

  // ***********************************************************
  // Instruction cycle flip-flops
  // ***********************************************************
  logic fic_r;
  logic sic_r;
  logic ia_r;
  logic exec_r;
  logic fexec_r;
  logic [1:0] exec_cnt_r;
  logic format_r;
  logic mod8_r;
  logic mod9_r;
  logic [4:0] op_r;
  logic [1:0] tag_r;
  logic sic_due;
  logic ia_due;
  logic exec_nxt;
  logic op_reset;

  assign sic_due = fic_r & format_r & ~end_op_i;
  assign ia_due = sic_r & format_r & mod8_r & ~end_op_i;
  assign exec_nxt = ~end_op_i & (exec_r | ((fic_r | sic_r | ia_r) & ~sic_due & ~ia_due));
  // The op register group clears when the next first cycle starts
  assign op_reset = at_zero & end_op_i; // RULE23

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fic_r <= 1'b1;
      sic_r <= 1'b0;
      ia_r <= 1'b0;
      exec_r <= 1'b0;
      fexec_r <= 1'b0;
      exec_cnt_r <= 2'h0;
    end else if (at_zero) begin
      fic_r <= end_op_i; // RULE6
      sic_r <= sic_due; // RULE7
      ia_r <= ia_due; // RULE8
      exec_r <= exec_nxt; // RULE9
      fexec_r <= exec_nxt & ~exec_r; // RULE10
      if (!exec_nxt) begin
        exec_cnt_r <= 2'h0;
      end else if (exec_cnt_r != 2'h3) begin
        exec_cnt_r <= exec_cnt_r + 2'h1; // RULE10
      end
    end
  end

  // ***********************************************************
  // Op, format, tag and modifier fields
  // ***********************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || op_reset) begin
      op_r <= 5'h00;
      format_r <= 1'b0;
      tag_r <= 2'h0;
    end else if (at_two && fic_r) begin
      for (int i = 0; i < 5; i++) begin
        op_r[4-i] <= word_bit(buffer_word_i, i); // RULE14
      end
      format_r <= word_bit(buffer_word_i, 5); // RULE15
      tag_r <= {word_bit(buffer_word_i, 6), word_bit(buffer_word_i, 7)}; // RULE16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mod8_r <= 1'b0;
      mod9_r <= 1'b0;
    end else begin
      mod8_r <= mod8_r & ~op_reset;
      mod9_r <= mod9_r & ~op_reset;
      if ((at_two && fic_r && word_bit(buffer_word_i, 8)) || add_to_storage_interlock_i) begin
        mod8_r <= 1'b1; // RULE17
      end
      if (at_two && fic_r && word_bit(buffer_word_i, 9)) begin
        mod9_r <= 1'b1; // RULE18
      end
    end
  end

  // ***********************************************************
  // Check flags
  // ***********************************************************
  logic flag_a_r;
  logic viol_r;
  logic par_r;
  logic viol_set;
  logic par_set;
  logic check_raise;

  assign viol_set = mem_ev_i.wr_gate & mem_ev_i.protect_bit;
  // Odd parity: an even count including the parity bit is an error
  assign par_set = mem_ev_i.parity_sample & mem_ev_i.write_use &
                   ~(^{buffer_word_i, mem_ev_i.parity_bit});
  assign check_raise = ((viol_set & ~viol_r) | (par_set & ~par_r)) & ~mem_ev_i.io_data_cycle;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_a_r <= 1'b0;
    end else if (at_four && fic_r && !VALID_OPS[op_r]) begin
      flag_a_r <= 1'b1; // RULE1
    end else if (op_reset) begin
      flag_a_r <= 1'b0;
    end
  end

  // A set in the cycle of a buffer reset wins so no error is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      viol_r <= 1'b0;
      par_r <= 1'b0;
    end else begin
      viol_r <= viol_set | (viol_r & ~mem_ev_i.buf_reset); // RULE2
      par_r <= par_set | (par_r & ~mem_ev_i.buf_reset); // RULE4
    end
  end

  // ***********************************************************
  // Carry, overflow and timer A
  // ***********************************************************
  logic carry_r;
  logic ovf_r;
  logic timer_stop_r;
  logic carry_set;
  logic carry_clr;
  logic ovf_set;
  logic ovf_clr;

  assign carry_set = dp_ev_i.arith_carry | (dp_ev_i.shift_left & dp_ev_i.acc_bit0) |
                     (dp_ev_i.load_status & dp_ev_i.ls_bit14) |
                     (dp_ev_i.shift_left_count & dp_ev_i.branch_both & ~dp_ev_i.shift_cnt_zero);
  assign carry_clr = dp_ev_i.bsc_test_carry | (dp_ev_i.load_status & dp_ev_i.ls_clr_carry) |
                     (dp_ev_i.shift_left_count & dp_ev_i.branch_both & dp_ev_i.shift_cnt_zero);
  assign ovf_set = dp_ev_i.arith_ovf | (dp_ev_i.load_status & dp_ev_i.ls_set_ovf);
  assign ovf_clr = dp_ev_i.bsc_test_ovf | (dp_ev_i.load_status & dp_ev_i.ls_clr_ovf);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      carry_r <= 1'b0;
      ovf_r <= 1'b0;
    end else if (adv) begin
      carry_r <= carry_set | (carry_r & ~carry_clr); // RULE19 RULE20
      ovf_r <= ovf_set | (ovf_r & ~ovf_clr); // RULE21
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timer_stop_r <= cpu_ctl_pkg::TIMER_STOP_RST;
    end else if (bus_wr && wb_adr_i == cpu_ctl_pkg::OFS_TIMER && wb_sel_i[0]) begin
      timer_stop_r <= ~timer_wv[cpu_ctl_pkg::TIMER_MOD0]; // RULE11
    end
  end

  // ***********************************************************
  // Interrupt levels
  // ***********************************************************
  logic [cpu_ctl_pkg::LEVELS-1:0] req_meta_r;
  logic [cpu_ctl_pkg::LEVELS-1:0] req_sync_r;
  logic [cpu_ctl_pkg::LEVELS-1:0] level_r;
  logic branch_out;

  // Ends the service routine: conditional branch with modifier 9
  assign branch_out = at_zero & end_op_i & exec_r & mod9_r &
                      (op_r == cpu_ctl_pkg::OP_CONDITIONAL_BRANCH_SKIP);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_meta_r <= 27'h0000000;
      req_sync_r <= 27'h0000000;
    end else begin
      req_meta_r <= level_request_i;
      req_sync_r <= req_meta_r;
    end
  end

  generate
    for (genvar g = 0; g < cpu_ctl_pkg::LEVELS; g++) begin : g_level
      logic set_l;
      if (g == cpu_ctl_pkg::LVL_CHECK) begin : g_check
        assign set_l = (req_sync_r[g] | check_raise) & ~mask_r[g]; // RULE3 RULE5
      end else begin : g_plain
        assign set_l = req_sync_r[g] & ~mask_r[g]; // RULE12
      end
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          level_r[g] <= 1'b0;
        end else begin
          level_r[g] <= set_l |
                        (level_r[g] & ~(branch_out && service_level_i == 5'(g))); // RULE13
        end
      end
    end
  endgenerate

  // ***********************************************************
  // Output and read-back registers
  // ***********************************************************
  logic [31:0] status_v;
  logic [31:0] fields_v;

  always_comb begin
    status_v = 32'h0;
    status_v[cpu_ctl_pkg::ST_FIC] = fic_r;
    status_v[cpu_ctl_pkg::ST_SIC] = sic_r;
    status_v[cpu_ctl_pkg::ST_IA] = ia_r;
    status_v[cpu_ctl_pkg::ST_EXEC] = exec_r;
    status_v[cpu_ctl_pkg::ST_FEXEC] = fexec_r;
    status_v[cpu_ctl_pkg::ST_SEXEC] = exec_cnt_r == 2'h2;
    status_v[cpu_ctl_pkg::ST_TEXEC] = exec_cnt_r == 2'h3;
    status_v[cpu_ctl_pkg::ST_FLAG_A] = flag_a_r;
    status_v[cpu_ctl_pkg::ST_VIOL] = viol_r;
    status_v[cpu_ctl_pkg::ST_PARITY] = par_r;
    status_v[cpu_ctl_pkg::ST_CARRY] = carry_r;
    status_v[cpu_ctl_pkg::ST_OVF] = ovf_r;
    status_v[cpu_ctl_pkg::ST_TIMER_STOP] = timer_stop_r;
    status_v[cpu_ctl_pkg::ST_STOPPED] = ~run_r;
    status_v[cpu_ctl_pkg::ST_PHASE_LSB +: 8] = phase_r;
    fields_v = 32'h0;
    fields_v[cpu_ctl_pkg::FLD_OP_LSB +: 5] = op_r;
    fields_v[cpu_ctl_pkg::FLD_FORMAT] = format_r;
    fields_v[cpu_ctl_pkg::FLD_TAG_LSB +: 2] = tag_r;
    fields_v[cpu_ctl_pkg::FLD_MOD8] = mod8_r;
    fields_v[cpu_ctl_pkg::FLD_MOD9] = mod9_r;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_r <= 32'h0;
    end else if (bus_req && !wb_we_i) begin
      case (wb_adr_i)
        cpu_ctl_pkg::OFS_CTRL: wb_dat_r <= {31'h0, run_r};
        cpu_ctl_pkg::OFS_STATUS: wb_dat_r <= status_v;
        cpu_ctl_pkg::OFS_FIELDS: wb_dat_r <= fields_v;
        cpu_ctl_pkg::OFS_LEVELS: wb_dat_r <= {5'h00, level_r};
        cpu_ctl_pkg::OFS_MASK: wb_dat_r <= {5'h00, mask_r};
        default: wb_dat_r <= 32'h0;
      endcase
    end
  end

  // The bus gate and op reset outputs lag by one cycle, the price of registered ports
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      address_bus_gate_o <= 1'b0;
      op_register_reset_o <= 1'b0;
    end else begin
      address_bus_gate_o <= storage_address_cycle_i | ~run_r; // RULE22
      op_register_reset_o <= op_reset;
    end
  end

  assign wb_ack_o = wb_ack_r;
  assign wb_dat_o = wb_dat_r;
  assign phase_o = phase_r;
  assign first_instruction_cycle_o = fic_r;
  assign second_instruction_cycle_o = sic_r;
  assign indirect_cycle_o = ia_r;
  assign execute_cycle_o = exec_r;
  assign first_execute_cycle_o = fexec_r;
  assign flag_a_o = flag_a_r;
  assign storage_violation_flag_o = viol_r;
  assign parity_error_flag_o = par_r;
  assign carry_flag_o = carry_r;
  assign overflow_flag_o = ovf_r;
  assign timer_a_stop_o = timer_stop_r;
  assign level_o = level_r;

endmodule // cpu_cycle_and_status_flags

// >>> sim/cpu_cycle_and_status_flags_asserts.sv
// Port-level assertions for the cycle and status flag block
`timescale 1ns/1ps
module cpu_flags_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [15:0] buffer_word_i,
  input wire cpu_ctl_pkg::mem_ev_t mem_ev_i,
  input wire logic storage_address_cycle_i,
  input wire logic [7:0] phase_o,
  input wire logic first_instruction_cycle_o,
  input wire logic second_instruction_cycle_o,
  input wire logic execute_cycle_o,
  input wire logic first_execute_cycle_o,
  input wire logic flag_a_o,
  input wire logic storage_violation_flag_o,
  input wire logic parity_error_flag_o,
  input wire logic timer_a_stop_o,
  input wire logic [cpu_ctl_pkg::LEVELS-1:0] level_o,
  input wire logic address_bus_gate_o,
  input wire logic op_register_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_phase_rotate:
    assert property (phase_o != $past(phase_o) |->
      phase_o == {$past(phase_o[6:0]), $past(phase_o[7])}) else $error("phase skipped");
  a_first_at_zero:
    assert property ($changed(first_instruction_cycle_o) |-> $past(phase_o) == 8'h01)
      else $error("first cycle timing");
  a_second_span:
    assert property ($rose(second_instruction_cycle_o) |-> $past(first_instruction_cycle_o)
      ##0 second_instruction_cycle_o[*8] ##1 !second_instruction_cycle_o)
      else $error("second span");
  a_first_exec_span:
    assert property ($rose(first_execute_cycle_o) |-> execute_cycle_o ##8 !first_execute_cycle_o)
      else $error("exec span");
  a_flag_a_time:
    assert property ($rose(flag_a_o) |-> $past(phase_o) == 8'h10 && $past(first_instruction_cycle_o))
      else $error("flag_a timing");
  a_viol_set:
    assert property (mem_ev_i.wr_gate && mem_ev_i.protect_bit |=> storage_violation_flag_o)
      else $error("violation missed");
  a_parity_set:
    assert property (mem_ev_i.parity_sample && mem_ev_i.write_use
      && ~^{buffer_word_i, mem_ev_i.parity_bit} |=> parity_error_flag_o)
      else $error("parity error missed");
  a_check_level:
    assert property (($rose(storage_violation_flag_o) || $rose(parity_error_flag_o))
      && !mem_ev_i.io_data_cycle && !$past(mem_ev_i.io_data_cycle)
      |-> ##[0:3] level_o[cpu_ctl_pkg::LVL_CHECK]) else $error("check level");
  a_timer_cmd:
    assert property (wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
      && wb_adr_i == cpu_ctl_pkg::OFS_TIMER |=> timer_a_stop_o == !$past(wb_dat_i[0]))
      else $error("timer cmd");
  a_opreset_first:
    assert property (op_register_reset_o |-> first_instruction_cycle_o)
      else $error("op reset timing");
  a_addr_gate:
    assert property (!$past(rst_i) && $past(storage_address_cycle_i) |-> address_bus_gate_o)
      else $error("bus gate");
  c_second: cover property ($rose(second_instruction_cycle_o));
  c_flag_a: cover property ($rose(flag_a_o));
  c_check: cover property ($rose(level_o[cpu_ctl_pkg::LVL_CHECK]));
  c_branch_out: cover property ($fell(level_o[7]));
endmodule // cpu_flags_checker

bind cpu_cycle_and_status_flags cpu_flags_checker i_chk (.*);

// >>> sim/storage_io_model.sv
// Behavioural core storage and interrupting devices
`timescale 1ns/1ps
module storage_io_model (
  input wire logic clk_i,
  input wire logic [26:0] req_i,
  output cpu_ctl_pkg::mem_ev_t mem_ev_o = '0,
  output logic [26:0] req_o
);
  int seed = 74;
  logic [8:0] r;
  logic [5:0] n = 6'h00;
  // Devices hold a request until the bench withdraws it
  assign req_o = req_i;
  // Long data cycles keep most check events clear of an edge
  always @(posedge clk_i) begin
    r = 9'($random(seed));
    n <= n + 6'h01;
    mem_ev_o <= {r[0], r[1] & r[2], r[3], r[4], r[5],
      (n == 6'h3F) ^ mem_ev_o.io_data_cycle, &r[8:6]};
  end
endmodule // storage_io_model

// >>> sim/cpu_cycle_and_status_flags_tb.sv
// Self-checking bench with a reference model of cycles and flags
`timescale 1ns/1ps
module cpu_cycle_and_status_flags_tb;
  localparam logic [31:0] VOPS = 32'hAAAA_AAAA;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [15:0] buffer_word_i = 16'h0000;
  cpu_ctl_pkg::mem_ev_t mem_ev_i;
  cpu_ctl_pkg::dp_ev_t dp_ev_i = '0, d;
  logic end_op_i = 1'b0, storage_address_cycle_i = 1'b0, dir = 1'b0;
  logic [4:0] service_level_i = 5'h07;
  logic [26:0] req = '0, level_request_i, level_o;
  logic [7:0] phase_o;
  logic wb_ack_o, first_instruction_cycle_o, second_instruction_cycle_o, indirect_cycle_o;
  logic execute_cycle_o, first_execute_cycle_o, flag_a_o, storage_violation_flag_o;
  logic parity_error_flag_o, carry_flag_o, overflow_flag_o, timer_a_stop_o;
  logic address_bus_gate_o, op_register_reset_o, add_to_storage_interlock_i = 1'b0;
  logic fic, sic, ia, ex, fe, fa, vi, pa, ca, ov, fm, m8, m9, ns, ni, nx;
  logic [4:0] op;
  int ph, seed = 74, err_total = 0, cmp_count = 0;

  cpu_cycle_and_status_flags #(.VALID_OPS(VOPS)) i_dut (.*);
  storage_io_model i_mem (.clk_i, .req_i(req), .mem_ev_o(mem_ev_i), .req_o(level_request_i));

  initial forever #2 clk_i = ~clk_i;

  task check(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] v);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= a;
    wb_dat_i <= v;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask

  task test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ***********************************************
  // Stimulus and reference model
  // ***********************************************
  // Load-status, shift and count qualifiers only come with their operation
  always @(posedge clk_i) begin
    if (!dir) begin
      end_op_i <= ($random(seed) & 3) == 0;
      buffer_word_i <= 16'($random(seed));
      add_to_storage_interlock_i <= ($random(seed) & 63) == 0;
    end
    d = 14'($random(seed) & $random(seed));
    d.acc_bit0 &= d.shift_left;
    d.ls_bit14 &= d.load_status;
    d.ls_clr_carry &= d.load_status;
    d.ls_set_ovf &= d.load_status;
    d.ls_clr_ovf &= d.load_status;
    d.branch_both &= d.shift_left_count;
    dp_ev_i <= d;
    storage_address_cycle_i <= 1'($random(seed));
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ph = 0;
      {fic, sic, ia, ex, fe, fa, vi, pa, ca, ov, op, fm, m8, m9} = {1'b1, 17'h0};
    end else begin
      check(phase_o, 8'h01 << ph);
      check({first_instruction_cycle_o, second_instruction_cycle_o, indirect_cycle_o,
        execute_cycle_o, first_execute_cycle_o, flag_a_o}, {fic, sic, ia, ex, fe, fa});
      check({storage_violation_flag_o, parity_error_flag_o, carry_flag_o, overflow_flag_o},
        {vi, pa, ca, ov});
      if (ph == 0) begin
        ns = fic & fm & !end_op_i;
        ni = sic & fm & m8 & !end_op_i;
        nx = !end_op_i & (ex | ((fic | sic | ia) & !ns & !ni));
        {fe, ex, sic, ia, fic} = {nx & !ex, nx, ns, ni, end_op_i};
        if (end_op_i) {op, fm, m8, m9, fa} = '0;
      end
      if (ph == 2 && fic)
        {op, fm, m8, m9} = {buffer_word_i[15:10], buffer_word_i[7:6] | {m8, m9}};
      m8 |= add_to_storage_interlock_i;
      if (ph == 4 && fic && !VOPS[op]) fa = 1'b1;
      vi = (mem_ev_i.wr_gate & mem_ev_i.protect_bit) | (vi & !mem_ev_i.buf_reset);
      pa = (mem_ev_i.parity_sample & mem_ev_i.write_use & ~^{buffer_word_i, mem_ev_i.parity_bit})
        | (pa & !mem_ev_i.buf_reset);
      ca = d_set(1) | (ca & !d_set(0));
      ov = dp_ev_i.arith_ovf | dp_ev_i.ls_set_ovf
        | (ov & !(dp_ev_i.bsc_test_ovf | dp_ev_i.ls_clr_ovf));
      ph = (ph + 1) % 8;
    end
  end

  function automatic logic d_set(input logic s);
    logic sc;
    sc = dp_ev_i.shift_left_count & dp_ev_i.branch_both & (dp_ev_i.shift_cnt_zero ^ s);
    if (s)
      return dp_ev_i.arith_carry | (dp_ev_i.shift_left & dp_ev_i.acc_bit0)
        | (dp_ev_i.load_status & dp_ev_i.ls_bit14) | sc;
    return dp_ev_i.bsc_test_carry | dp_ev_i.ls_clr_carry | sc;
  endfunction

  initial begin
    #20000;
    err_total++;
    test_done;
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(0, cpu_ctl_pkg::OFS_CTRL, 0);
    check(q[cpu_ctl_pkg::CTRL_RUN], cpu_ctl_pkg::RUN_RST);
    wb(0, cpu_ctl_pkg::OFS_MASK, 0);
    check(q, 32'h0);
    wb(0, cpu_ctl_pkg::OFS_LEVELS, 0);
    check(q[23:0], 24'h0);
    wb(0, 8'h18, 0);
    check(q, 32'h0);
    wb(0, cpu_ctl_pkg::OFS_STATUS, 0);
    check(q[cpu_ctl_pkg::ST_TIMER_STOP], cpu_ctl_pkg::TIMER_STOP_RST);
    for (int v = 1; v >= 0; v--) begin
      wb(1, cpu_ctl_pkg::OFS_TIMER, 32'(v));
      wb(0, cpu_ctl_pkg::OFS_STATUS, 0);
      check(q[cpu_ctl_pkg::ST_TIMER_STOP], v == 0);
      check(timer_a_stop_o, v == 0);
    end
    $display("register test done");
    wb(1, cpu_ctl_pkg::OFS_MASK, 32'h20);
    req <= 27'h0A0;
    repeat (8) @(posedge clk_i);
    check({level_o[7], level_o[5]}, 2'b10);
    dir = 1'b1;
    end_op_i <= 1'b1;
    buffer_word_i <= 16'h4840;
    repeat (16) @(posedge clk_i);
    end_op_i <= 1'b0;
    req <= '0;
    repeat (5) @(posedge clk_i);
    wb(0, cpu_ctl_pkg::OFS_FIELDS, 0);
    check(q[9:0], {m9, m8, 2'b00, fm, op});
    check(level_o[7], 1);
    end_op_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    check(level_o[7], 0);
    dir = 1'b0;
    $display("level test done");
    repeat (2000) @(posedge clk_i);
    $display("random run done");
    test_done;
  end
endmodule // cpu_cycle_and_status_flags_tb
